// File: rtl/tws_eeprom.sv
// Serial EEPROM command, protocol, array and register logic
`timescale 1ns/10ps
// What this block does
// - First clock rise with select and input high is the start bit.
// - Before a start bit, clocks and input changes do nothing.
// - Instructions execute only after all their bits arrived.
// - After the last bit, inputs are ignored until a new start bit.
// - Reset leaves programming locked; unlock holds until lock.
// - Reads run whatever the lock state.
// - Read sends a zero, then the word MSB first, changing on rises.
// - Continued clocking streams following words with address increment.
// - Word erase sets the word to ones; timing starts on last address bit.
// - Write takes 16 or 8 data bits; timing starts on the last one.
// - During programming, output shows 0 busy, 1 ready, until start.
// - Select low floats the output and goes to standby.
// - Word write and word erase take about 3 ms.
// - Erase entire sets the array to ones; low address bits ignored.
// - Erase entire takes 8 ms typical, within 15 ms.
// - Write entire fills every word, erasing first, needs unlock.
// - Write entire takes 16 ms typical, within 30 ms.
// - A started programming cycle completes even if select drops.
// - Select low holds decoding in reset and ignores the clock.
// - Clock may pause at any level; shift state is kept.
// - No clock is needed during programming; timing is internal.
// - Bits are sampled and launched on rising serial clock edges.
// - Start 1, opcode read 10, write 01, erase 11, 00 extended.
// - Word width select high gives 16-bit words, low 8-bit.
module tws_eeprom
  import tws_pkg::*;
#(
  parameter logic [19:0] WORD_CYC      = TWS_WORD_CYC,
  parameter logic [19:0] ERASE_ALL_CYC = TWS_ERASE_ALL_CYC,
  parameter logic [19:0] WRITE_ALL_CYC = TWS_WRITE_ALL_CYC
) (
  input  wire logic            mclk,
  input  wire logic            resetn,
  input  wire logic            select,
  input  wire logic            sclk,
  input  wire logic            serial_input,
  input  wire logic            word_width_select,
  output logic                 serial_output,
  output logic                 serial_output_en,
  input  wire tws_axi_req_type axi_req,
  output tws_axi_rsp_type      axi_rsp
);
  typedef struct packed {
    logic [1:0]        sel_q;
    logic [2:0]        clk_q;
    logic [1:0]        din_q;
    logic [1:0]        wsel_q;
    tws_state_type     state;
    logic [4:0]        cnt;
    logic [1:0]        op;
    logic [10:0]       addr;
    logic [15:0]       data;
    logic [15:0]       rword;
    logic [4:0]        rcnt;
    logic              unlocked;
    logic              permit;
    logic              busy;
    logic              show;
    logic              dout;
    logic              oe;
    tws_prog_type      pkind;
    logic [19:0]       timer;
    logic              aw_got;
    logic              w_got;
    logic [7:0]        awaddr;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
    logic [TWS_WORDS-1:0][7:0] mem;
  } tws_reg_type;

  tws_reg_type st;
  tws_reg_type next_st;
  logic [1:0]  rst_q;
  logic        rst_n;
  logic        rise;
  logic        sel;
  logic        wide;
  logic [4:0]  hlen;
  logic [4:0]  dlen;

  function automatic logic [15:0] tws_fetch(input logic [TWS_WORDS-1:0][7:0] m,
                                            input logic [10:0] a, input logic w);
    if (w) begin
      return {m[{a[9:0], 1'b0}], m[{a[9:0], 1'b1}]};
    end
    return {m[a], 8'h00};
  endfunction : tws_fetch

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rst_q <= 2'h0;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_n = rst_q[1];

  // Pins are sampled after the second sync stage; the serial clock edge is found there
  assign rise = st.clk_q[1] & ~st.clk_q[2];
  assign sel  = st.sel_q[1];
  assign wide = st.wsel_q[1];
  assign hlen = wide ? TWS_HLEN_W16 : TWS_HLEN_W8;
  assign dlen = wide ? TWS_DLEN_W16 : TWS_DLEN_W8;

  always_comb begin
    logic             bin;
    logic [4:0]       nc;
    logic [1:0]       sub;
    logic             go;
    tws_prog_type     kind;
    logic [15:0]      wv;
    bin  = st.din_q[1];
    nc   = st.cnt + 5'h01;
    sub  = 2'h0;
    go   = 1'b0;
    kind = PK_WORD_ERASE;
    wv   = 16'hFFFF;
    next_st = st;
    next_st.sel_q = {st.sel_q[0], select};
    next_st.clk_q = {st.clk_q[1:0], sclk};
    next_st.din_q = {st.din_q[0], serial_input};
    next_st.wsel_q = {st.wsel_q[0], word_width_select};

    // Register bus
    if (axi_req.awvalid && !st.aw_got && !st.bvalid) begin
      next_st.aw_got = 1'b1;
      next_st.awaddr = axi_req.awaddr;
    end
    if (axi_req.wvalid && !st.w_got && !st.bvalid) begin
      next_st.w_got = 1'b1;
      next_st.wdata = axi_req.wdata;
      next_st.wstrb = axi_req.wstrb;
    end
    if (st.bvalid && axi_req.bready) begin
      next_st.bvalid = 1'b0;
    end
    if (st.aw_got && st.w_got) begin
      next_st.aw_got = 1'b0;
      next_st.w_got  = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp  = TWS_RESP_OKAY;
      if (st.awaddr == TWS_ADDR_CTRL) begin
        if (st.wstrb[0]) begin
          next_st.permit = st.wdata[TWS_CTRL_PERMIT];
          if (st.wdata[TWS_CTRL_LOCK]) begin
            next_st.unlocked = 1'b0;
          end
        end
      end else if (st.awaddr != TWS_ADDR_STATUS) begin
        next_st.bresp = TWS_RESP_SLVERR;
      end
    end
    if (st.rvalid && axi_req.rready) begin
      next_st.rvalid = 1'b0;
    end
    if (axi_req.arvalid && !st.rvalid) begin
      next_st.rvalid = 1'b1;
      next_st.rresp  = TWS_RESP_OKAY;
      next_st.rdata  = 32'h0;
      if (axi_req.araddr == TWS_ADDR_CTRL) begin
        next_st.rdata[TWS_CTRL_PERMIT] = st.permit;
      end else if (axi_req.araddr == TWS_ADDR_STATUS) begin
        next_st.rdata[3:0] = {st.show, wide, st.unlocked, st.busy};
      end else begin
        next_st.rresp = TWS_RESP_SLVERR;
      end
    end

    // Self-timed programming runs on mclk alone, whatever select does
    if (st.busy) begin
      next_st.timer = st.timer - 20'h1;
      if (st.timer == 20'h1) begin
        next_st.busy = 1'b0;
        if (st.pkind == PK_WORD_WRITE || st.pkind == PK_ALL_WRITE) begin
          wv = st.data;
        end
        if (st.pkind == PK_ALL_ERASE || st.pkind == PK_ALL_WRITE) begin
          for (int i = 0; i < TWS_WORDS; i++) begin
            next_st.mem[i] = (wide && (i % 2 == 0)) ? wv[15:8] : wv[7:0];
          end
        end else if (wide) begin
          next_st.mem[{st.addr[9:0], 1'b0}] = wv[15:8];
          next_st.mem[{st.addr[9:0], 1'b1}] = wv[7:0];
        end else begin
          next_st.mem[st.addr] = wv[7:0];
        end
      end
    end

    if (!sel) begin
      next_st.state = ST_WAIT;
      next_st.show  = 1'b0;
    end else if (st.busy) begin
      // Reselecting during a cycle brings the busy display back for polling
      next_st.show  = 1'b1;
    end else if (rise) begin
      case (st.state)
        ST_WAIT: begin
          if (bin) begin
            next_st.state = ST_CMD;
            next_st.cnt   = 5'h00;
            next_st.addr  = 11'h000;
            next_st.show  = 1'b0;
          end
        end
        ST_CMD: begin
          next_st.cnt = nc;
          if (st.cnt < 5'h02) begin
            next_st.op = {st.op[0], bin};
          end else if (st.cnt < hlen) begin
            next_st.addr = {st.addr[9:0], bin};
          end else begin
            next_st.data = {st.data[14:0], bin};
          end
          sub = wide ? next_st.addr[9:8] : next_st.addr[10:9];
          if (nc == hlen) begin
            next_st.state = ST_WAIT;
            case (next_st.op)
              TWS_OP_READ: begin
                next_st.state = ST_READ;
                next_st.dout  = 1'b0;
                next_st.rword = tws_fetch(st.mem, next_st.addr, wide);
                next_st.rcnt  = dlen;
              end
              TWS_OP_ERASE: begin
                go = 1'b1;
              end
              TWS_OP_EXT: begin
                case (sub)
                  TWS_SUB_UNLOCK: next_st.unlocked = 1'b1;
                  TWS_SUB_LOCK: next_st.unlocked = 1'b0;
                  TWS_SUB_ERALL: begin
                    go   = 1'b1;
                    kind = PK_ALL_ERASE;
                  end
                  default: next_st.state = ST_CMD;
                endcase
              end
              default: next_st.state = ST_CMD;
            endcase
          end else if (nc == hlen + dlen) begin
            next_st.state = ST_WAIT;
            go   = 1'b1;
            kind = (st.op == TWS_OP_WRITE) ? PK_WORD_WRITE : PK_ALL_WRITE;
          end
        end
        ST_READ: begin
          next_st.dout  = st.rword[15];
          next_st.rword = {st.rword[14:0], 1'b0};
          next_st.rcnt  = st.rcnt - 5'h01;
          if (st.rcnt == 5'h01) begin
            next_st.addr  = st.addr + 11'h001;
            next_st.rword = tws_fetch(st.mem, next_st.addr, wide);
            next_st.rcnt  = dlen;
          end
        end
        default: next_st.state = ST_WAIT;
      endcase
    end

    // Rejected while locked or while software withholds permission
    if (go && st.unlocked && st.permit) begin
      next_st.busy  = 1'b1;
      next_st.show  = 1'b1;
      next_st.pkind = kind;
      case (kind)
        PK_ALL_ERASE: next_st.timer = ERASE_ALL_CYC;
        PK_ALL_WRITE: next_st.timer = WRITE_ALL_CYC;
        default: next_st.timer = WORD_CYC;
      endcase
    end
    if (next_st.show) begin
      next_st.dout = ~next_st.busy;
    end
    // Only the second sync stage is read and oe is registered, so the float lags select by three mclk edges
    next_st.oe = sel && (next_st.show || next_st.state == ST_READ);
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st        <= '0;
      st.state  <= ST_WAIT;
      st.permit <= TWS_PERMIT_RST;
      st.mem    <= '1;
    end else begin
      st <= next_st;
    end
  end

  assign serial_output    = st.dout;
  assign serial_output_en = st.oe;
  assign axi_rsp.awready  = ~st.aw_got & ~st.bvalid;
  assign axi_rsp.wready   = ~st.w_got & ~st.bvalid;
  assign axi_rsp.bvalid   = st.bvalid;
  assign axi_rsp.bresp    = st.bresp;
  assign axi_rsp.arready  = ~st.rvalid;
  assign axi_rsp.rvalid   = st.rvalid;
  assign axi_rsp.rdata    = st.rdata;
  assign axi_rsp.rresp    = st.rresp;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  a_start_detect: assert property (
    st.state == ST_WAIT && sel && rise && st.din_q[1] && !st.busy |=> st.state == ST_CMD)
    else $error("start bit not taken");
  a_idle_hold: assert property (
    st.state == ST_WAIT && !st.din_q[1] && !(st.aw_got && st.w_got) |=>
      st.state == ST_WAIT && $stable(st.unlocked))
    else $error("idle state changed without start");
  a_prog_cause: assert property (
    $rose(st.busy) |-> $past(st.state) == ST_CMD && $past(st.unlocked) &&
      ($past(st.cnt) == hlen - 5'h01 || $past(st.cnt) == hlen + dlen - 5'h01))
    else $error("programming without full locked-out check");
  a_read_zero: assert property (
    $rose(st.state == ST_READ) && sel |-> st.dout == 1'b0 && st.oe)
    else $error("read lacks leading zero");
  a_read_incr: assert property (
    st.state == ST_READ && sel && rise && st.rcnt == 5'h01 |=>
      st.addr == $past(st.addr) + 11'h001)
    else $error("sequential read address not advanced");
  a_status_level: assert property (
    st.show |-> st.dout == ~st.busy)
    else $error("status bit wrong");
  a_desel_float: assert property (
    !sel |=> !serial_output_en)
    else $error("output driven while deselected");
  a_word_time: assert property (
    $rose(st.busy) && (st.pkind == PK_WORD_ERASE || st.pkind == PK_WORD_WRITE) |->
      st.timer == WORD_CYC)
    else $error("word cycle length wrong");
  a_erase_all_time: assert property (
    $rose(st.busy) && st.pkind == PK_ALL_ERASE |-> st.timer == ERASE_ALL_CYC)
    else $error("erase entire length wrong");
  a_write_all_time: assert property (
    $rose(st.busy) && st.pkind == PK_ALL_WRITE |-> st.timer == WRITE_ALL_CYC)
    else $error("write entire length wrong");
  a_prog_survive: assert property (
    st.busy && st.timer > 20'h1 |=> st.busy)
    else $error("programming cut short");
  a_desel_reset: assert property (
    !sel |=> st.state == ST_WAIT)
    else $error("decoder not reset by deselect");
  a_pause_keep: assert property (
    st.state == ST_CMD && sel && !rise |=> $stable(st.cnt) && $stable(st.addr))
    else $error("shift state lost during pause");

  c_read_start: cover property ($rose(st.state == ST_READ));
  c_prog_start: cover property ($rose(st.busy));
  c_seq_read: cover property (st.state == ST_READ && rise && st.rcnt == 5'h01 && sel);
  c_ready_seen: cover property (st.show && !st.busy && st.oe);
endmodule : tws_eeprom

// File: pkg/tws_pkg.sv
// Constants, types and register map for the three-wire serial EEPROM
package tws_pkg;
  localparam int TWS_CLK_HZ       = 50_000_000;
  localparam int TWS_CYC_PER_MS   = TWS_CLK_HZ / 1000;
  localparam int TWS_WORD_MS      = 3;
  localparam int TWS_ERASE_ALL_MS = 8;
  localparam int TWS_WRITE_ALL_MS = 16;
  localparam logic [19:0] TWS_WORD_CYC      = 20'(TWS_WORD_MS * TWS_CYC_PER_MS);
  localparam logic [19:0] TWS_ERASE_ALL_CYC = 20'(TWS_ERASE_ALL_MS * TWS_CYC_PER_MS);
  localparam logic [19:0] TWS_WRITE_ALL_CYC = 20'(TWS_WRITE_ALL_MS * TWS_CYC_PER_MS);

  localparam logic [4:0] TWS_HLEN_W16 = 5'h0C;
  localparam logic [4:0] TWS_HLEN_W8  = 5'h0D;
  localparam logic [4:0] TWS_DLEN_W16 = 5'h10;
  localparam logic [4:0] TWS_DLEN_W8  = 5'h08;
  localparam int         TWS_WORDS    = 2048;

  localparam logic [1:0] TWS_OP_EXT     = 2'h0;
  localparam logic [1:0] TWS_OP_WRITE   = 2'h1;
  localparam logic [1:0] TWS_OP_READ    = 2'h2;
  localparam logic [1:0] TWS_OP_ERASE   = 2'h3;
  localparam logic [1:0] TWS_SUB_LOCK   = 2'h0;
  localparam logic [1:0] TWS_SUB_WRALL  = 2'h1;
  localparam logic [1:0] TWS_SUB_ERALL  = 2'h2;
  localparam logic [1:0] TWS_SUB_UNLOCK = 2'h3;

  localparam logic [7:0] TWS_ADDR_CTRL   = 8'h00;
  localparam logic [7:0] TWS_ADDR_STATUS = 8'h04;
  localparam int         TWS_CTRL_PERMIT = 0;
  localparam int         TWS_CTRL_LOCK   = 1;
  localparam logic       TWS_PERMIT_RST  = 1'b1;
  localparam logic [1:0] TWS_RESP_OKAY   = 2'h0;
  localparam logic [1:0] TWS_RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    ST_WAIT = 3'h1,
    ST_CMD  = 3'h2,
    ST_READ = 3'h4
  } tws_state_type;

  typedef enum logic [1:0] {
    PK_WORD_ERASE = 2'h0,
    PK_WORD_WRITE = 2'h1,
    PK_ALL_ERASE  = 2'h2,
    PK_ALL_WRITE  = 2'h3
  } tws_prog_type;

  typedef struct packed {
    logic       awvalid;
    logic [7:0] awaddr;
    logic       wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic       bready;
    logic       arvalid;
    logic [7:0] araddr;
    logic       rready;
  } tws_axi_req_type;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } tws_axi_rsp_type;
endpackage : tws_pkg

// File: tb/tws_host.sv
// Serial bus master model for the three-wire EEPROM link
`timescale 1ns/10ps
module tws_host (
  input  wire logic mclk,
  input  wire logic do_pin,
  output logic      select,
  output logic      sclk,
  output logic      serial_input
);
  // Clock stands low between frames
  initial begin
    select = 1'b0;
    sclk = 1'b0;
    serial_input = 1'b0;
  end

  // Four system clocks make half of the 160 ns link period
  task automatic half();
    repeat (4) @(posedge mclk);
  endtask : half

  // A second call within one frame is a pause with the clock held low
  task automatic send(input logic [31:0] v, input int n);
    int i;
    select <= 1'b1;
    half();
    for (i = n - 1; i >= 0; i--) begin
      serial_input <= v[i];
      sclk <= 1'b0;
      half();
      sclk <= 1'b1;
      half();
    end
    sclk <= 1'b0;
    serial_input <= 1'b0;
    half();
  endtask : send

  // Sampled a full period after each rise, at the end of the low phase, past the launch delay
  task automatic recv(input int n, output logic [31:0] q);
    int i;
    q = 32'h0;
    for (i = 0; i < n; i++) begin
      sclk <= 1'b1;
      half();
      sclk <= 1'b0;
      half();
      q = {q[30:0], do_pin};
    end
  endtask : recv

  // Held low long enough to pass the device's synchroniser
  task automatic deselect();
    select <= 1'b0;
    half();
    half();
  endtask : deselect
endmodule : tws_host

// File: tb/tb_tws_eeprom.sv
// Self-checking bench for the three-wire serial EEPROM block
`timescale 1ns/10ps
module tb_tws_eeprom
  import tws_pkg::*;
;
  logic            mclk;
  logic            resetn;
  logic            w16;
  logic            select;
  logic            sclk;
  logic            serial_input;
  logic            serial_output;
  logic            serial_output_en;
  tws_axi_req_type req;
  tws_axi_rsp_type rsp;
  int              n_errors;
  int              check_count;
  wire             do_pin = serial_output_en ? serial_output : 1'bz;

  // Short programming times keep the run brief
  tws_eeprom #(
    .WORD_CYC      (20'h00028),
    .ERASE_ALL_CYC (20'h00050),
    .WRITE_ALL_CYC (20'h000A0)
  ) tws_eeprom_i (
    .mclk              (mclk),
    .resetn            (resetn),
    .select            (select),
    .sclk              (sclk),
    .serial_input      (serial_input),
    .word_width_select (w16),
    .serial_output     (serial_output),
    .serial_output_en  (serial_output_en),
    .axi_req           (req),
    .axi_rsp           (rsp)
  );

  tws_host tws_host_i (
    .mclk         (mclk),
    .do_pin       (do_pin),
    .select       (select),
    .sclk         (sclk),
    .serial_input (serial_input)
  );

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  task automatic give_verdict();
    $display("Checks %0d, errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int i;
    @(posedge mclk);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= 4'hF;
    req.bready <= 1'b1;
    for (i = 0; i < 50 && rsp.bvalid !== 1'b1; i++) begin
      @(posedge mclk);
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
    end
    req.bready <= 1'b0;
    chk("bvalid", {31'h0, rsp.bvalid}, 32'h1);
    chk("bresp", {30'h0, rsp.bresp}, {30'h0, er});
    if (i == 50) give_verdict();
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    int i;
    @(posedge mclk);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    for (i = 0; i < 50 && rsp.rvalid !== 1'b1; i++) begin
      @(posedge mclk);
      if (rsp.arready) req.arvalid <= 1'b0;
    end
    req.rready <= 1'b0;
    chk("rvalid", {31'h0, rsp.rvalid}, 32'h1);
    chk("rdata", rsp.rdata, e);
    chk("rresp", {30'h0, rsp.rresp}, {30'h0, er});
    if (i == 50) give_verdict();
  endtask : axi_rd

  task automatic cmd(input logic [1:0] op, input logic [10:0] a, input logic [15:0] d,
                     input logic dat);
    logic [31:0] v;
    int          n;
    n = w16 ? 13 : 14;
    v = w16 ? {19'h0, 1'b1, op, a[9:0]} : {18'h0, 1'b1, op, a};
    if (dat) begin
      v = w16 ? {v[15:0], d} : {v[23:0], d[7:0]};
      n = n + (w16 ? 16 : 8);
    end
    tws_host_i.send(v, n);
  endtask : cmd

  // Don't-care address bits are sent as ones
  task automatic ext(input logic [1:0] sub, input logic [15:0] d);
    cmd(TWS_OP_EXT, w16 ? {1'b0, sub, 8'hFF} : {sub, 9'h1FF}, d, sub == TWS_SUB_WRALL);
  endtask : ext

  task automatic rdw(input logic [10:0] a, input logic [15:0] e, input logic more);
    logic [31:0] q;
    cmd(TWS_OP_READ, a, 16'h0, 1'b0);
    chk("dummy bit", {31'h0, do_pin}, 32'h0);
    tws_host_i.recv(w16 ? 16 : 8, q);
    chk("read word", q, {16'h0, e});
    if (!more) tws_host_i.deselect();
  endtask : rdw

  // No serial clock is given while the device times itself
  task automatic prog_wait(input int lo);
    int i;
    chk("busy", {31'h0, do_pin}, 32'h0);
    for (i = 0; i < 400 && do_pin !== 1'b1; i++) begin
      @(posedge mclk);
    end
    chk("ready", {31'h0, do_pin}, 32'h1);
    chk("cycle length", {31'h0, i >= lo}, 32'h1);
    tws_host_i.deselect();
    chk("released", {31'h0, serial_output_en}, 32'h0);
    if (i == 400) give_verdict();
  endtask : prog_wait

  initial begin
    logic [31:0] q;
    n_errors = 0;
    check_count = 0;
    resetn = 1'b0;
    w16 = 1'b1;
    req = '0;
    repeat (4) @(posedge mclk);
    resetn <= 1'b1;
    repeat (4) @(posedge mclk);
    axi_rd(TWS_ADDR_STATUS, 32'h00000004, TWS_RESP_OKAY);
    axi_rd(TWS_ADDR_CTRL, 32'h00000001, TWS_RESP_OKAY);
    axi_rd(8'h08, 32'h00000000, TWS_RESP_SLVERR);
    axi_wr(8'h0C, 32'h00000000, TWS_RESP_SLVERR);
    tws_host_i.send(32'h00000000, 5);
    cmd(TWS_OP_WRITE, 11'h005, 16'h1234, 1'b1);
    chk("locked write", {31'h0, serial_output_en}, 32'h0);
    tws_host_i.deselect();
    rdw(11'h005, 16'hFFFF, 1'b0);
    ext(TWS_SUB_UNLOCK, 16'h0000);
    tws_host_i.deselect();
    axi_rd(TWS_ADDR_STATUS, 32'h00000006, TWS_RESP_OKAY);
    // Write of word 6 cut off after ten of its data bits
    tws_host_i.send(32'h00501800, 23);
    tws_host_i.deselect();
    cmd(TWS_OP_WRITE, 11'h005, 16'hA5C3, 1'b1);
    axi_rd(TWS_ADDR_STATUS, 32'h0000000F, TWS_RESP_OKAY);
    prog_wait(16);
    rdw(11'h005, 16'hA5C3, 1'b1);
    tws_host_i.recv(16, q);
    chk("next word", q, 32'h0000FFFF);
    tws_host_i.deselect();
    cmd(TWS_OP_ERASE, 11'h005, 16'h0000, 1'b0);
    tws_host_i.deselect();
    axi_rd(TWS_ADDR_STATUS, 32'h00000007, TWS_RESP_OKAY);
    // Reselect while the erase still runs: the busy display must return
    tws_host_i.send(32'h00000000, 0);
    prog_wait(8);
    rdw(11'h005, 16'hFFFF, 1'b0);
    ext(TWS_SUB_WRALL, 16'h3C3C);
    prog_wait(120);
    rdw(11'h3FF, 16'h3C3C, 1'b0);
    axi_wr(TWS_ADDR_CTRL, 32'h00000003, TWS_RESP_OKAY);
    axi_rd(TWS_ADDR_STATUS, 32'h00000004, TWS_RESP_OKAY);
    cmd(TWS_OP_ERASE, 11'h000, 16'h0000, 1'b0);
    chk("locked erase", {31'h0, serial_output_en}, 32'h0);
    tws_host_i.deselect();
    rdw(11'h000, 16'h3C3C, 1'b0);
    w16 <= 1'b0;
    repeat (8) @(posedge mclk);
    ext(TWS_SUB_UNLOCK, 16'h0000);
    tws_host_i.deselect();
    // Software withholding permission must block an unlocked erase
    axi_wr(TWS_ADDR_CTRL, 32'h00000000, TWS_RESP_OKAY);
    axi_rd(TWS_ADDR_CTRL, 32'h00000000, TWS_RESP_OKAY);
    cmd(TWS_OP_ERASE, 11'h00B, 16'h0000, 1'b0);
    chk("withheld erase", {31'h0, serial_output_en}, 32'h0);
    tws_host_i.deselect();
    axi_wr(TWS_ADDR_CTRL, 32'h00000001, TWS_RESP_OKAY);
    cmd(TWS_OP_WRITE, 11'h00B, 16'h0096, 1'b1);
    prog_wait(16);
    rdw(11'h00B, 16'h0096, 1'b0);
    w16 <= 1'b1;
    repeat (8) @(posedge mclk);
    rdw(11'h005, 16'h3C96, 1'b0);
    ext(TWS_SUB_ERALL, 16'h0000);
    prog_wait(50);
    rdw(11'h005, 16'hFFFF, 1'b0);
    ext(TWS_SUB_LOCK, 16'h0000);
    tws_host_i.deselect();
    axi_rd(TWS_ADDR_STATUS, 32'h00000004, TWS_RESP_OKAY);
    give_verdict();
  end
endmodule : tb_tws_eeprom
